/* logic/qa_watchdog_pkg.sv */
// Shared constants for the question-and-answer watchdog status and answer logic
package qa_watchdog_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int WIN_STEP_NS = 550000;
	localparam int WIN_STEP_CYCLES = (WIN_STEP_NS / 1000) * (CLK_HZ / 1000000);
	localparam int STEP_W = 16;
	// ----------------------------------------------------------------
	// Serial frame commands
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_RD_STATUS = 8'h4E;
	localparam logic [7:0] CMD_WR_ANSWER = 8'hE1;
	localparam logic [7:0] FILL_BYTE = 8'h00;
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] CMD_BITS = 5'h08;
	// ----------------------------------------------------------------
	// Status field positions
	// ----------------------------------------------------------------
	localparam int ST_FAIL_TH = 7;
	localparam int ST_ANS_CNT_HI = 6;
	localparam int ST_ANS_CNT_LO = 5;
	localparam int ST_CFG_CHG = 4;
	localparam int ST_BAD_ANS = 3;
	localparam int ST_SEQ = 2;
	localparam int ST_TIME_OUT = 1;
	localparam int ST_EARLY = 0;
	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic FAIL_TH_INIT = 1'b1;
	localparam logic [1:0] ANS_CNT_MULTI_INIT = 2'h3;
	localparam logic [1:0] ANS_CNT_SINGLE_INIT = 2'h1;
	localparam logic [3:0] QUESTION_INIT = 4'hC;
	localparam logic [7:0] WIN1_INIT = 8'hFF;
	localparam logic [4:0] WIN2_INIT = 5'h1F;
	localparam logic [7:0] QA_CFG_INIT = 8'h0A;
	localparam logic [2:0] SEQ_MIN_WIN1 = 3'h3;
	localparam logic [2:0] MULTI_ANSWERS = 3'h4;
	localparam logic [2:0] SINGLE_ANSWERS = 3'h1;
	localparam logic MODE_MULTI = 1'b0;
endpackage

/* logic/serial_frame_port.sv */
// Serial control port: samples the link pins, frames command and data bytes
`timescale 1ns/1ns
`default_nettype none
module serial_frame_port (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic mosi_in,
	input wire logic [7:0] tx_byte_in,
	output logic cmd_valid_out,
	output logic [7:0] cmd_out,
	output logic data_valid_out,
	output logic [7:0] data_out,
	output logic miso_out
);
	logic [2:0] sclk_sync_reg;
	logic [1:0] cs_sync_reg;
	logic [1:0] mosi_sync_reg;
	logic [4:0] bit_cnt_reg;
	logic [15:0] rx_reg;
	logic [7:0] tx_reg;
	logic cmd_valid_reg;
	logic data_valid_reg;
	logic miso_reg;
	wire logic sclk_rise;
	wire logic sclk_fall;
	wire logic cs_active;
	wire logic [15:0] rx_next;
	wire logic [4:0] bit_cnt_next;

	// Edges are taken between the second and third stage only
	assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
	assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
	assign cs_active = ~cs_sync_reg[1];
	assign rx_next = {rx_reg[14:0], mosi_sync_reg[1]};
	assign bit_cnt_next = bit_cnt_reg + 5'h01;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			sclk_sync_reg <= 3'h0;
			cs_sync_reg <= 2'h3;
			mosi_sync_reg <= 2'h0;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_in};
			cs_sync_reg <= {cs_sync_reg[0], cs_n_in};
			mosi_sync_reg <= {mosi_sync_reg[0], mosi_in};
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in || !cs_active) begin
			bit_cnt_reg <= 5'h00;
			rx_reg <= 16'h0000;
		end else if (sclk_rise && bit_cnt_reg != qa_watchdog_pkg::FRAME_BITS) begin
			bit_cnt_reg <= bit_cnt_next;
			rx_reg <= rx_next;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			cmd_valid_reg <= 1'b0;
			data_valid_reg <= 1'b0;
		end else begin
			cmd_valid_reg <= cs_active && sclk_rise && bit_cnt_next == qa_watchdog_pkg::CMD_BITS;
			data_valid_reg <= cs_active && sclk_rise && bit_cnt_next == qa_watchdog_pkg::FRAME_BITS;
		end
	end

	// Reply bits change on falling edges, so the host samples them stable on rising ones
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in || !cs_active) begin
			tx_reg <= qa_watchdog_pkg::FILL_BYTE;
			miso_reg <= 1'b0;
		end else if (cmd_valid_reg) begin
			tx_reg <= tx_byte_in;
		end else if (sclk_fall && bit_cnt_reg >= qa_watchdog_pkg::CMD_BITS) begin
			miso_reg <= tx_reg[7];
			tx_reg <= {tx_reg[6:0], 1'b0};
		end
	end

	assign cmd_valid_out = cmd_valid_reg;
	assign data_valid_out = data_valid_reg;
	assign cmd_out = rx_reg[7:0];
	assign data_out = rx_reg[7:0];
	assign miso_out = miso_reg;
endmodule
`default_nettype wire

/* logic/qa_watchdog_status_answer.sv */
// Watchdog answer collection, cycle judgement and clear-on-read status register
`timescale 1ns/1ns
`default_nettype none
module qa_watchdog_status_answer #(
	parameter int STEP_CYCLES = qa_watchdog_pkg::WIN_STEP_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic device_reset_state_in,
	input wire logic spi_sclk_in,
	input wire logic spi_cs_n_in,
	input wire logic spi_mosi_in,
	input wire logic window_mode_select_in,
	input wire logic [7:0] first_window_setting_in,
	input wire logic [4:0] second_window_setting_in,
	input wire logic [7:0] question_answer_setting_in,
	input wire logic [3:0] failure_counter_in,
	input wire logic [3:0] drive_threshold_in,
	input wire logic [7:0] expected_response_in,
	input wire logic [3:0] next_question_in,
	output logic spi_miso_out,
	output logic [3:0] current_question_out,
	output logic cycle_end_out,
	output logic in_window_one_out
);
	logic init_reg;
	logic write_cmd_reg;
	logic mode_reg;
	logic [7:0] win1_reg;
	logic [4:0] win2_reg;
	logic [7:0] qa_cfg_reg;
	logic [qa_watchdog_pkg::STEP_W-1:0] step_cnt_reg;
	logic [7:0] win_cnt_reg;
	logic win_one_reg;
	logic cycle_end_reg;
	logic [2:0] win1_answers_reg;
	logic [2:0] total_answers_reg;
	logic wrong_seen_reg;
	logic [1:0] answer_cnt_reg;
	logic fail_th_reg;
	logic cfg_chg_reg;
	logic bad_answer_reg;
	logic seq_fault_reg;
	logic time_out_reg;
	logic early_reg;
	logic [3:0] question_reg;
	wire logic cmd_valid;
	wire logic [7:0] cmd_byte;
	wire logic data_valid;
	wire logic [7:0] data_byte;
	wire logic miso;
	wire logic init;
	wire logic status_read;
	wire logic answer_write;
	wire logic step_done;
	wire logic win_done;
	wire logic cfg_diff;
	wire logic multi;
	wire logic below_th;
	wire logic [1:0] answer_cnt_init;
	wire logic [7:0] status_byte;
	wire logic [2:0] total_next;
	wire logic [2:0] win1_next;
	wire logic seq_end;
	wire logic time_out_end;
	wire logic early_end;

	function automatic logic [2:0] sat_inc(input logic [2:0] v, input logic en);
		sat_inc = (en && v != 3'h7) ? v + 3'h1 : v;
	endfunction

	// ----------------------------------------------------------------
	// Serial port
	// ----------------------------------------------------------------
	serial_frame_port port_inst (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.sclk_in(spi_sclk_in),
		.cs_n_in(spi_cs_n_in),
		.mosi_in(spi_mosi_in),
		.tx_byte_in(status_byte),
		.cmd_valid_out(cmd_valid),
		.cmd_out(cmd_byte),
		.data_valid_out(data_valid),
		.data_out(data_byte),
		.miso_out(miso)
	);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	assign init = sys_rst_in | device_reset_state_in;
	assign status_read = cmd_valid && cmd_byte == qa_watchdog_pkg::CMD_RD_STATUS;
	// Only a completed write frame is an answer; status reads never count
	assign answer_write = data_valid && write_cmd_reg && init_reg && !init;
	assign multi = mode_reg == qa_watchdog_pkg::MODE_MULTI;
	assign below_th = failure_counter_in < drive_threshold_in;
	assign answer_cnt_init = window_mode_select_in == qa_watchdog_pkg::MODE_MULTI ?
		qa_watchdog_pkg::ANS_CNT_MULTI_INIT : qa_watchdog_pkg::ANS_CNT_SINGLE_INIT;
	assign cfg_diff = window_mode_select_in != mode_reg || first_window_setting_in != win1_reg ||
		second_window_setting_in != win2_reg || question_answer_setting_in != qa_cfg_reg;
	assign status_byte = {fail_th_reg, answer_cnt_reg, cfg_chg_reg, bad_answer_reg, seq_fault_reg,
		time_out_reg, early_reg};
	assign total_next = sat_inc(total_answers_reg, answer_write);
	assign win1_next = sat_inc(win1_answers_reg, answer_write && win_one_reg);
	assign seq_end = multi && win1_next < qa_watchdog_pkg::SEQ_MIN_WIN1;
	assign time_out_end = multi ? total_next < qa_watchdog_pkg::MULTI_ANSWERS :
		total_next < qa_watchdog_pkg::SINGLE_ANSWERS;
	assign early_end = multi ? win1_next >= qa_watchdog_pkg::MULTI_ANSWERS :
		win1_next >= qa_watchdog_pkg::SINGLE_ANSWERS;

	// ----------------------------------------------------------------
	// Window timing
	// ----------------------------------------------------------------
	assign step_done = step_cnt_reg == qa_watchdog_pkg::STEP_W'(STEP_CYCLES - 1);
	assign win_done = step_done && (win_one_reg ? win_cnt_reg == win1_reg :
		win_cnt_reg == {3'h0, win2_reg});

	// A configuration change restarts the cycle so old windows never judge new answers
	always_ff @(posedge ref_clk_in) begin
		if (init || cfg_diff) begin
			step_cnt_reg <= '0;
			win_cnt_reg <= 8'h00;
			win_one_reg <= 1'b1;
			cycle_end_reg <= 1'b0;
		end else begin
			step_cnt_reg <= step_done ? '0 : step_cnt_reg + 1'b1;
			cycle_end_reg <= win_done && !win_one_reg;
			if (win_done) begin
				win_cnt_reg <= 8'h00;
				win_one_reg <= !win_one_reg;
			end else if (step_done) begin
				win_cnt_reg <= win_cnt_reg + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration shadow
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			init_reg <= 1'b0;
			mode_reg <= qa_watchdog_pkg::MODE_MULTI;
			win1_reg <= qa_watchdog_pkg::WIN1_INIT;
			win2_reg <= qa_watchdog_pkg::WIN2_INIT;
			qa_cfg_reg <= qa_watchdog_pkg::QA_CFG_INIT;
		end else begin
			init_reg <= 1'b1;
			mode_reg <= window_mode_select_in;
			win1_reg <= first_window_setting_in;
			win2_reg <= second_window_setting_in;
			qa_cfg_reg <= question_answer_setting_in;
		end
	end

	// ----------------------------------------------------------------
	// Per-cycle answer bookkeeping
	// ----------------------------------------------------------------
	// Command byte of the frame in progress decides what its data byte is
	always_ff @(posedge ref_clk_in) begin
		if (init) begin
			write_cmd_reg <= 1'b0;
		end else if (cmd_valid) begin
			write_cmd_reg <= cmd_byte == qa_watchdog_pkg::CMD_WR_ANSWER;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (init || cfg_diff || cycle_end_reg) begin
			win1_answers_reg <= 3'h0;
			total_answers_reg <= 3'h0;
			wrong_seen_reg <= 1'b0;
		end else begin
			win1_answers_reg <= win1_next;
			total_answers_reg <= total_next;
			if (answer_write && data_byte != expected_response_in) begin
				wrong_seen_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (init || cfg_diff || cycle_end_reg) begin
			answer_cnt_reg <= answer_cnt_init;
		end else if (answer_write) begin
			answer_cnt_reg <= answer_cnt_reg - 2'h1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (init) begin
			question_reg <= qa_watchdog_pkg::QUESTION_INIT;
		end else if (cycle_end_reg) begin
			question_reg <= next_question_in;
		end
	end

	// ----------------------------------------------------------------
	// Status flags: an event in the read cycle beats the clear
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (init) begin
			fail_th_reg <= qa_watchdog_pkg::FAIL_TH_INIT;
		end else if (!below_th) begin
			fail_th_reg <= 1'b0;
		end else if (status_read) begin
			fail_th_reg <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (init) begin
			cfg_chg_reg <= 1'b0;
		end else if (cfg_diff) begin
			cfg_chg_reg <= 1'b1;
		end else if (status_read) begin
			cfg_chg_reg <= 1'b0;
		end
	end

	// Time-out stays set after reconfiguration so the host can resynchronise
	always_ff @(posedge ref_clk_in) begin
		if (init) begin
			bad_answer_reg <= 1'b0;
			seq_fault_reg <= 1'b0;
			time_out_reg <= 1'b0;
			early_reg <= 1'b0;
		end else if (cycle_end_reg) begin
			bad_answer_reg <= wrong_seen_reg || (answer_write && data_byte != expected_response_in);
			seq_fault_reg <= seq_end;
			time_out_reg <= time_out_end;
			early_reg <= early_end;
		end else if (status_read) begin
			bad_answer_reg <= 1'b0;
			seq_fault_reg <= 1'b0;
			time_out_reg <= 1'b0;
			early_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign spi_miso_out = miso;
	assign current_question_out = question_reg;
	assign cycle_end_out = cycle_end_reg;
	assign in_window_one_out = win_one_reg;
endmodule
`default_nettype wire

/* sim/qa_watchdog_status_answer_chk.sv */
// Port-level assertions for the watchdog status and answer block
`timescale 1ns/1ns
`default_nettype none
module qa_watchdog_status_answer_chk #(
	parameter int STEP_CYCLES = 4
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic device_reset_state_in,
	input wire logic spi_sclk_in,
	input wire logic spi_cs_n_in,
	input wire logic window_mode_select_in,
	input wire logic [7:0] first_window_setting_in,
	input wire logic [4:0] second_window_setting_in,
	input wire logic [7:0] question_answer_setting_in,
	input wire logic [3:0] next_question_in,
	input wire logic spi_miso_out,
	input wire logic [3:0] current_question_out,
	input wire logic cycle_end_out,
	input wire logic in_window_one_out
);
	default clocking @(posedge ref_clk_in); endclocking
	wire rst = sys_rst_in | device_reset_state_in;
	int hi_cnt, lo_cnt, w1_len, w2_len;
	assign w1_len = (int'(first_window_setting_in) + 1) * STEP_CYCLES;
	assign w2_len = (int'(second_window_setting_in) + 1) * STEP_CYCLES;
	// --------
	// Window run lengths
	// --------
	// A setting change restarts the timers, so the run counts restart too
	always_ff @(posedge ref_clk_in) begin
		if (rst || $changed({window_mode_select_in, first_window_setting_in, second_window_setting_in,
			question_answer_setting_in})) begin
			hi_cnt <= 0;
			lo_cnt <= 0;
		end else begin
			hi_cnt <= in_window_one_out ? hi_cnt + 1 : 0;
			lo_cnt <= in_window_one_out ? 0 : lo_cnt + 1;
		end
	end
	a_reset_values: assert property (rst |=> current_question_out == 4'hC && !cycle_end_out
		&& in_window_one_out && !spi_miso_out) else $error("bad reset outputs");
	a_end_single: assert property (disable iff (rst) cycle_end_out |=> !cycle_end_out)
		else $error("long cycle end");
	a_question_load: assert property (disable iff (rst)
		cycle_end_out |-> ##[0:1] current_question_out == next_question_in) else $error("question not loaded");
	a_win1_restart: assert property (disable iff (rst) cycle_end_out |-> ##[0:2] in_window_one_out)
		else $error("window one not restarted");
	a_end_after_win2: assert property (disable iff (rst) cycle_end_out |-> !$past(in_window_one_out))
		else $error("end inside window one");
	a_win1_length: assert property (disable iff (rst)
		$fell(in_window_one_out) |-> hi_cnt >= w1_len && hi_cnt <= w1_len + 2) else $error("window one length");
	a_win2_length: assert property (disable iff (rst)
		cycle_end_out |-> lo_cnt >= w2_len - 1 && lo_cnt <= w2_len + 2) else $error("window two length");
	a_miso_idle: assert property (disable iff (rst) spi_cs_n_in [*4] |-> !spi_miso_out)
		else $error("reply line not idle");
	a_miso_steady: assert property (disable iff (rst)
		(spi_sclk_in && !spi_cs_n_in) [*3] |-> $stable(spi_miso_out)) else $error("reply moved on high clock");
	c_cycle_end: cover property (cycle_end_out);
	c_win1_done: cover property ($fell(in_window_one_out));
	c_frame_done: cover property (!spi_cs_n_in ##1 spi_cs_n_in);
endmodule
bind qa_watchdog_status_answer qa_watchdog_status_answer_chk #(.STEP_CYCLES(STEP_CYCLES)) chk (.ref_clk_in,
	.sys_rst_in, .device_reset_state_in, .spi_sclk_in, .spi_cs_n_in, .window_mode_select_in, .first_window_setting_in,
	.second_window_setting_in, .question_answer_setting_in, .next_question_in, .spi_miso_out, .current_question_out,
	.cycle_end_out, .in_window_one_out);
`default_nettype wire

/* sim/spi_host_model.sv */
// Serial host model sending command and data frames
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
	output logic sclk_out,
	output logic cs_n_out,
	output logic mosi_out,
	input wire logic miso_in
);
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		mosi_out = 1'b0;
	end
	// Clock stands low between frames; released data line shows the inverse
	task automatic frame(input logic [7:0] cmd, input logic [7:0] dat, output logic [7:0] rd);
		logic [15:0] sh;
		sh = {cmd, dat};
		#13 cs_n_out = 1'b0;
		for (int i = 0; i < 16; i++) begin
			mosi_out = sh[15 - i];
			#160 sclk_out = 1'b1;
			if (i > 7) rd = {rd[6:0], miso_in};
			#160 sclk_out = 1'b0;
		end
		#160 cs_n_out = 1'b1;
		mosi_out = ~mosi_out;
		#200;
	endtask
endmodule
`default_nettype wire

/* sim/qa_watchdog_status_answer_tb.sv */
// Self-checking bench for the watchdog status and answer block
`timescale 1ns/1ns
`default_nettype none
module qa_watchdog_status_answer_tb;
	localparam logic [7:0] GOOD = 8'hA5;
	localparam logic [7:0] RD = qa_watchdog_pkg::CMD_RD_STATUS;
	localparam logic [7:0] WR = qa_watchdog_pkg::CMD_WR_ANSWER;
	logic ref_clk_in = 1'b0, sys_rst_in = 1'b1, device_reset_state_in = 1'b0, window_mode_select_in = 1'b0;
	logic spi_sclk_in, spi_cs_n_in, spi_mosi_in, spi_miso_out, cycle_end_out, in_window_one_out;
	logic [7:0] first_window_setting_in = 8'hFF, question_answer_setting_in = 8'h0A, expected_response_in = GOOD, rd;
	logic [4:0] second_window_setting_in = 5'h1F;
	logic [3:0] failure_counter_in = 4'h0, drive_threshold_in = 4'h5, next_question_in = 4'h3, current_question_out;
	int err_count = 0;
	int n_checks = 0;
	// Ten clocks a step so window two holds two whole answer frames
	qa_watchdog_status_answer #(.STEP_CYCLES(10)) DUT (.ref_clk_in, .sys_rst_in, .device_reset_state_in,
		.spi_sclk_in, .spi_cs_n_in, .spi_mosi_in, .window_mode_select_in, .first_window_setting_in,
		.second_window_setting_in, .question_answer_setting_in, .failure_counter_in, .drive_threshold_in,
		.expected_response_in, .next_question_in, .spi_miso_out, .current_question_out, .cycle_end_out,
		.in_window_one_out);
	spi_host_model host (.sclk_out(spi_sclk_in), .cs_n_out(spi_cs_n_in), .mosi_out(spi_mosi_in), .miso_in(spi_miso_out));
	initial begin
		forever #20 ref_clk_in = ~ref_clk_in;
	end
	// --------
	// Shared tasks
	// --------
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
		n_checks++;
		if ((got & mask) !== (exp & mask)) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic status(input logic [7:0] exp, input logic [7:0] mask);
		host.frame(RD, qa_watchdog_pkg::FILL_BYTE, rd);
		check(rd, exp, mask);
	endtask
	task automatic wait_for(input logic end_not_win);
		for (int n = 0; (end_not_win ? cycle_end_out : !in_window_one_out) !== 1'b1; n++) begin
			@(negedge ref_clk_in);
			if (n > 4000) begin
				err_count++;
				$display("[ERR] %0t wait timed out", $time);
				end_of_test;
			end
		end
	endtask
	// Each judged cycle starts after a clean cycle end; status reads are not answers
	task automatic run_cycle(input int n1, input int n2, input logic [7:0] a0, input logic [7:0] exp,
		input logic [7:0] mask);
		wait_for(1'b1);
		for (int i = 0; i < n1 + n2; i++) begin
			if (i == n1) wait_for(1'b0);
			host.frame(WR, i == 0 ? a0 : GOOD, rd);
		end
		wait_for(1'b1);
		status(exp, mask);
	endtask
	task automatic t_reset;
		status(8'hE0, 8'hFF);
		check({4'h0, current_question_out}, 8'h0C, 8'hFF);
	endtask
	task automatic t_good;
		run_cycle(3, 1, GOOD, 8'hE0, 8'hFF);
		check({4'h0, current_question_out}, 8'h03, 8'hFF);
	endtask
	task automatic t_silent;
		run_cycle(0, 0, GOOD, 8'hE6, 8'hFF);
		status(8'hE0, 8'hFF);
		host.frame(WR, GOOD, rd);
		status(8'hC0, 8'hFF);
	endtask
	task automatic t_miscount;
		run_cycle(4, 0, 8'h5A, 8'hE9, 8'hFF);
		run_cycle(2, 2, GOOD, 8'hE4, 8'hFF);
	endtask
	task automatic t_fail;
		@(negedge ref_clk_in);
		failure_counter_in = 4'h5;
		status(8'h00, 8'h80);
		@(negedge ref_clk_in);
		failure_counter_in = 4'h4;
		status(8'h00, 8'h80);
		status(8'h80, 8'h80);
	endtask
	task automatic t_cfg;
		for (int k = 0; k < 4; k++) begin
			@(negedge ref_clk_in);
			if (k == 0) first_window_setting_in[0] = 1'b0;
			if (k == 1) second_window_setting_in[0] = 1'b0;
			if (k == 2) question_answer_setting_in[0] = 1'b1;
			if (k == 3) window_mode_select_in = 1'b1;
			status(8'h10, 8'h10);
		end
		status(8'h00, 8'h10);
	endtask
	task automatic t_single;
		run_cycle(1, 0, GOOD, 8'hA1, 8'hEF);
		run_cycle(0, 1, GOOD, 8'hA0, 8'hEF);
		run_cycle(0, 0, GOOD, 8'hA2, 8'hEF);
	endtask
	task automatic t_devrst;
		@(negedge ref_clk_in);
		device_reset_state_in = 1'b1;
		repeat (2) @(negedge ref_clk_in);
		device_reset_state_in = 1'b0;
		repeat (2) @(negedge ref_clk_in);
		check({4'h0, current_question_out}, 8'h0C, 8'hFF);
		status(8'hA0, 8'hFF);
	endtask
	initial begin
		repeat (16) @(negedge ref_clk_in);
		sys_rst_in = 1'b0;
		repeat (2) @(negedge ref_clk_in);
		t_reset;
		t_good;
		t_silent;
		t_miscount;
		t_fail;
		t_cfg;
		t_single;
		t_devrst;
		end_of_test;
	end
endmodule
`default_nettype wire
